// >>> hw/fsap_fifo.sv
// Show-ahead FIFO of one serial data channel, flip-flop storage.
// Assumes push and pop from the same clock; push when full and pop
// when empty are ignored.
`timescale 1ns/1ps
module fsap_fifo #(
    parameter int DW = 32,
    parameter int AW = 3
) (
    input  wire logic          clk_in,
    input  wire logic          rst_n_in,
    input  wire logic          push_in,
    input  wire logic [DW-1:0] push_data_in,
    input  wire logic          pop_in,
    output logic      [DW-1:0] pop_data_out,
    output logic      [AW:0]   wr_ptr_out,
    output logic      [AW:0]   rd_ptr_out,
    output logic               full_out,
    output logic               empty_out
);

    logic [DW-1:0] mem_q [2**AW];
    logic [AW:0]   wr_q;
    logic [AW:0]   rd_q;

    if (AW < 1 || AW > 8) begin : g_chk
        $error("fsap_fifo: AW out of range");
    end

    // Wrap bit tells full from empty
    assign empty_out    = (wr_q == rd_q);
    assign full_out     = (wr_q == {~rd_q[AW], rd_q[AW-1:0]});
    assign pop_data_out = mem_q[rd_q[AW-1:0]];
    assign wr_ptr_out   = wr_q;
    assign rd_ptr_out   = rd_q;

    always_ff @(posedge clk_in) begin
        if (push_in && !full_out) begin
            mem_q[wr_q[AW-1:0]] <= push_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push_in && !full_out) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop_in && !empty_out) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end

endmodule : fsap_fifo

// >>> hw/fsap_pkg.sv
// Constants of the framed serial audio port: register map, fields, resets.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
package fsap_pkg;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_FRAME   = 8'h04;
    localparam logic [7:0] OFS_CLOCK   = 8'h08;
    localparam logic [7:0] OFS_STATUS  = 8'h0C;
    localparam logic [7:0] OFS_TXDATA0 = 8'h10;
    localparam logic [7:0] OFS_RXDATA0 = 8'h18;
    localparam logic [7:0] OFS_FPTR0   = 8'h20;
    localparam logic [7:0] OFS_STRIDE  = 8'h04;

    // ****************************************************************
    // Control fields
    // ****************************************************************
    localparam int CTRL_TX_ON     = 0;
    localparam int CTRL_RX_ON     = 1;
    localparam int CTRL_BCLK_ON   = 2;
    localparam int CTRL_MASTER    = 3;
    localparam int CTRL_STOP_RUN  = 4;
    localparam int CTRL_DEBUG_RUN = 5;
    localparam int CTRL_TXE_REQ   = 6;
    localparam int CTRL_RXF_REQ   = 7;
    localparam int CTRL_TXW_REQ   = 8;
    localparam int CTRL_RXW_REQ   = 9;

    // ****************************************************************
    // Frame, clock and pointer fields
    // ****************************************************************
    localparam int FRM_WLEN_LSB = 0;
    localparam int FRM_WNUM_LSB = 8;
    localparam int FRM_FSL_LSB  = 16;
    localparam int FRM_WM_LSB   = 24;
    localparam int CLK_BDIV_LSB = 0;
    localparam int CLK_MDIV_LSB = 8;
    localparam int CLK_MSRC     = 16;
    localparam int PTR_RD_LSB   = 16;

    // ****************************************************************
    // Status fields
    // ****************************************************************
    localparam int ST_FS_ERR   = 0;
    localparam int ST_WSTART   = 1;
    localparam int ST_TX_EMPTY = 2;
    localparam int ST_RX_FULL  = 3;
    localparam int ST_TX_REQ   = 4;
    localparam int ST_RX_REQ   = 5;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
    localparam logic [31:0] FRAME_RST = 32'h0200_1F1F;
    localparam logic [31:0] CLOCK_RST = 32'h0000_0000;

    typedef enum logic {FSAP_IDLE, FSAP_RUN} fsap_run_t;

endpackage : fsap_pkg

// >>> hw/fsap_top.sv
// Framed serial audio port: Wishbone registers, clock and frame sync
// generation, two transmit and two receive data channels.
// Assumes link pins are asynchronous to clk_in and are synchronised here.
`timescale 1ns/1ps
module fsap_top #(
    parameter int NCH = 2,
    parameter int AW  = 3
) (
    input  wire logic           clk_in,
    input  wire logic           rst_n_in,
    input  wire logic           wb_cyc_in,
    input  wire logic           wb_stb_in,
    input  wire logic           wb_we_in,
    input  wire logic [7:0]     wb_adr_in,
    input  wire logic [3:0]     wb_sel_in,
    input  wire logic [31:0]    wb_dat_in,
    output logic      [31:0]    wb_dat_out,
    output logic                wb_ack_out,
    input  wire logic           stop_mode_in,
    input  wire logic           debug_mode_in,
    input  wire logic           mclk_ext_in,
    output logic                mclk_out,
    input  wire logic           bclk_in,
    output logic                bclk_out,
    output logic                bclk_oe_out,
    input  wire logic           fs_in,
    output logic                fs_out,
    output logic                fs_oe_out,
    output logic      [NCH-1:0] tx_data_out,
    input  wire logic [NCH-1:0] rx_data_in,
    output logic                tx_req_out,
    output logic                rx_req_out
);

    localparam int SW = 3 + NCH;

    if (NCH != 2 || AW < 1 || AW > 5) begin : g_chk
        $error("fsap_top: NCH must be 2 and AW in 1..5");
    end

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [SW-1:0] s1_q, s2_q, s3_q;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= {rx_data_in, mclk_ext_in, fs_in, bclk_in};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // ****************************************************************
    // Registers and decode
    // ****************************************************************
    logic [31:0] ctrl_q, frame_q, clock_q;
    logic        fs_err_q, wstart_q, ack_q;
    logic [31:0] bmask, rd_d;
    logic        req, acc, wr_acc;
    logic [4:0]  wlm1, wnm1, fslm1;
    logic [AW:0] wm;
    logic        tx_on, rx_on, master, hold;

    assign req    = wb_cyc_in && wb_stb_in && !ack_q;
    assign acc    = wb_cyc_in && wb_stb_in && ack_q;
    assign wr_acc = acc && wb_we_in;
    assign bmask  = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}},
                     {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
    assign tx_on  = ctrl_q[fsap_pkg::CTRL_TX_ON];
    assign rx_on  = ctrl_q[fsap_pkg::CTRL_RX_ON];
    assign master = ctrl_q[fsap_pkg::CTRL_MASTER];
    assign wlm1   = frame_q[fsap_pkg::FRM_WLEN_LSB +: 5];
    assign wnm1   = frame_q[fsap_pkg::FRM_WNUM_LSB +: 5];
    assign fslm1  = frame_q[fsap_pkg::FRM_FSL_LSB +: 5];
    assign wm     = frame_q[fsap_pkg::FRM_WM_LSB +: AW+1];
    assign hold   = (stop_mode_in && !ctrl_q[fsap_pkg::CTRL_STOP_RUN])
                 || (debug_mode_in
                     && !ctrl_q[fsap_pkg::CTRL_DEBUG_RUN]);

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ctrl_q  <= fsap_pkg::CTRL_RST;
            frame_q <= fsap_pkg::FRAME_RST;
            clock_q <= fsap_pkg::CLOCK_RST;
        end else if (wr_acc) begin
            unique case (wb_adr_in)
                fsap_pkg::OFS_CTRL: begin
                    ctrl_q <= (ctrl_q & ~bmask) | (wb_dat_in & bmask);
                end
                fsap_pkg::OFS_FRAME: begin
                    frame_q <= (frame_q & ~bmask) | (wb_dat_in & bmask);
                end
                fsap_pkg::OFS_CLOCK: begin
                    clock_q <= (clock_q & ~bmask) | (wb_dat_in & bmask);
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************************************
    // Master and bit clock generation
    // ****************************************************************
    logic [7:0] mdiv_q, bdiv_q;
    logic       mclk_q, bclk_q, src_tick, mclk_tick, bwrap;
    logic       rise_ev, fall_ev;

    assign src_tick  = clock_q[fsap_pkg::CLK_MSRC] ? (s2_q[2] && !s3_q[2])
                                                    : 1'b1;
    assign mclk_tick = src_tick && !mclk_q
                    && (mdiv_q >= clock_q[fsap_pkg::CLK_MDIV_LSB +: 8]);
    assign bwrap     = mclk_tick
                    && (bdiv_q >= clock_q[fsap_pkg::CLK_BDIV_LSB +: 8]);

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            mdiv_q <= 8'h00;
            mclk_q <= 1'b0;
        end else if (src_tick) begin
            if (mdiv_q >= clock_q[fsap_pkg::CLK_MDIV_LSB +: 8]) begin
                mdiv_q <= 8'h00;
                mclk_q <= !mclk_q;
            end else begin
                mdiv_q <= mdiv_q + 8'h01;
            end
        end
    end

    // Free running while enabled, never gated per frame
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            bdiv_q <= 8'h00;
            bclk_q <= 1'b0;
        end else if (!ctrl_q[fsap_pkg::CTRL_BCLK_ON] || !master) begin
            bdiv_q <= 8'h00;
            bclk_q <= 1'b0;
        end else if (bwrap) begin
            bdiv_q <= 8'h00;
            bclk_q <= !bclk_q;
        end else if (mclk_tick) begin
            bdiv_q <= bdiv_q + 8'h01;
        end
    end

    // Data changes on falling and is sampled on rising bit clock
    always_comb begin
        rise_ev = 1'b0;
        fall_ev = 1'b0;
        if (ctrl_q[fsap_pkg::CTRL_BCLK_ON]) begin
            if (master) begin
                rise_ev = bwrap && !bclk_q;
                fall_ev = bwrap && bclk_q;
            end else begin
                rise_ev = s2_q[0] && !s3_q[0];
                fall_ev = !s2_q[0] && s3_q[0];
            end
        end
    end

    // ****************************************************************
    // Frame sequencing
    // ****************************************************************
    fsap_pkg::fsap_run_t run_q;
    logic [4:0] bit_q, word_q;
    logic       fs_prev_q, restart_q, last_bit, at_end, start_c, wstart_ev;
    logic       fs_rise;

    assign last_bit  = (bit_q == wlm1);
    assign at_end    = last_bit && (word_q == wnm1);
    assign start_c   = (tx_on || rx_on) && !hold
                    && (master ? (run_q == fsap_pkg::FSAP_IDLE || at_end)
                               : restart_q);
    assign wstart_ev = fall_ev && (start_c
                    || (run_q == fsap_pkg::FSAP_RUN && last_bit && !at_end));
    assign fs_rise   = rise_ev && s2_q[1] && !fs_prev_q;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            fs_prev_q <= 1'b0;
            restart_q <= 1'b0;
        end else begin
            if (rise_ev) begin
                fs_prev_q <= s2_q[1];
            end
            if (fs_rise && !master) begin
                restart_q <= 1'b1;
            end else if (fall_ev) begin
                restart_q <= 1'b0;
            end
        end
    end

    // Master frames repeat while an enable stays set and hold is clear; slave frames start only on an fs rise
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            run_q  <= fsap_pkg::FSAP_IDLE;
            bit_q  <= 5'h00;
            word_q <= 5'h00;
        end else if (fall_ev) begin
            if (start_c) begin
                run_q  <= fsap_pkg::FSAP_RUN;
                bit_q  <= 5'h00;
                word_q <= 5'h00;
            end else if (run_q == fsap_pkg::FSAP_RUN) begin
                if (at_end) begin
                    run_q <= fsap_pkg::FSAP_IDLE;
                end else if (last_bit) begin
                    bit_q  <= 5'h00;
                    word_q <= word_q + 5'h01;
                end else begin
                    bit_q <= bit_q + 5'h01;
                end
            end
        end
    end

    // Sync length alone picks I2S-like or network framing
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            fs_out    <= 1'b0;
            fs_oe_out <= 1'b0;
            bclk_out  <= 1'b0;
            bclk_oe_out <= 1'b0;
            mclk_out  <= 1'b0;
        end else begin
            fs_out <= master && run_q == fsap_pkg::FSAP_RUN
                   && word_q == 5'h00 && bit_q <= fslm1;
            fs_oe_out   <= master && (tx_on || rx_on);
            // Next bit clock level, so the pin edge meets the data change
            bclk_out    <= ctrl_q[fsap_pkg::CTRL_BCLK_ON] && master
                        && (bclk_q ^ bwrap);
            bclk_oe_out <= master && ctrl_q[fsap_pkg::CTRL_BCLK_ON];
            mclk_out    <= mclk_q;
        end
    end

    // Set wins over a write-one clear
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            fs_err_q <= 1'b0;
            wstart_q <= 1'b0;
        end else begin
            if (fall_ev && restart_q && run_q == fsap_pkg::FSAP_RUN
                && !at_end) begin
                fs_err_q <= 1'b1;
            end else if (wr_acc && wb_adr_in == fsap_pkg::OFS_STATUS
                         && wb_sel_in[0]
                         && wb_dat_in[fsap_pkg::ST_FS_ERR]) begin
                fs_err_q <= 1'b0;
            end
            if (wstart_ev) begin
                wstart_q <= 1'b1;
            end else if (wr_acc && wb_adr_in == fsap_pkg::OFS_STATUS
                         && wb_sel_in[0]
                         && wb_dat_in[fsap_pkg::ST_WSTART]) begin
                wstart_q <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Data channels
    // ****************************************************************
    logic [31:0]    tx_pd [NCH];
    logic [31:0]    rx_pd [NCH];
    logic [AW:0]    tx_wp [NCH], tx_rp [NCH], rx_wp [NCH], rx_rp [NCH];
    logic [NCH-1:0] tx_full, tx_empty, rx_full, rx_empty;
    logic [NCH-1:0] tx_wml, rx_wml;
    logic [31:0]    wmask;

    assign wmask = ~(32'hFFFF_FFFE << wlm1);

    for (genvar c = 0; c < NCH; c++) begin : g_ch
        logic [31:0] tsh_q, rsh_q, algn, rnext;
        logic        tpop, rpush, tpush, rpop;
        localparam logic [7:0] TXA = fsap_pkg::OFS_TXDATA0
                                   + 8'(c) * fsap_pkg::OFS_STRIDE;
        localparam logic [7:0] RXA = fsap_pkg::OFS_RXDATA0
                                   + 8'(c) * fsap_pkg::OFS_STRIDE;

        assign tpush = wr_acc && wb_adr_in == TXA && (|wb_sel_in);
        assign rpop  = acc && !wb_we_in && wb_adr_in == RXA;
        assign tpop  = wstart_ev && tx_on && !tx_empty[c];
        // Fixed MSB-first placement, no alignment choice
        assign algn  = tpop ? (tx_pd[c] << (5'd31 - wlm1)) : 32'h0;
        assign rnext = {rsh_q[30:0], s2_q[3+c]};
        assign rpush = rise_ev && run_q == fsap_pkg::FSAP_RUN
                    && rx_on && last_bit;

        fsap_fifo #(.DW(32), .AW(AW)) u_tx (
            .clk_in       (clk_in),
            .rst_n_in     (rst_n_in),
            .push_in      (tpush),
            .push_data_in (wb_dat_in),
            .pop_in       (tpop),
            .pop_data_out (tx_pd[c]),
            .wr_ptr_out   (tx_wp[c]),
            .rd_ptr_out   (tx_rp[c]),
            .full_out     (tx_full[c]),
            .empty_out    (tx_empty[c])
        );

        fsap_fifo #(.DW(32), .AW(AW)) u_rx (
            .clk_in       (clk_in),
            .rst_n_in     (rst_n_in),
            .push_in      (rpush),
            .push_data_in (rnext & wmask),
            .pop_in       (rpop),
            .pop_data_out (rx_pd[c]),
            .wr_ptr_out   (rx_wp[c]),
            .rd_ptr_out   (rx_rp[c]),
            .full_out     (rx_full[c]),
            .empty_out    (rx_empty[c])
        );

        assign tx_wml[c] = AW'(tx_wp[c] - tx_rp[c]) <= wm;
        assign rx_wml[c] = AW'(rx_wp[c] - rx_rp[c]) >= wm;

        always_ff @(posedge clk_in) begin
            if (!rst_n_in) begin
                tsh_q          <= 32'h0;
                tx_data_out[c] <= 1'b0;
            end else if (wstart_ev) begin
                tsh_q          <= {algn[30:0], 1'b0};
                tx_data_out[c] <= algn[31];
            end else if (fall_ev) begin
                tsh_q          <= {tsh_q[30:0], 1'b0};
                tx_data_out[c] <= (run_q == fsap_pkg::FSAP_RUN)
                                  && tsh_q[31];
            end
        end

        always_ff @(posedge clk_in) begin
            if (!rst_n_in) begin
                rsh_q <= 32'h0;
            end else if (rise_ev && run_q == fsap_pkg::FSAP_RUN) begin
                rsh_q <= rnext;
            end
        end
    end

    // ****************************************************************
    // Requests and bus answer
    // ****************************************************************
    logic tx_req_d, rx_req_d;

    assign tx_req_d = tx_on
        && ((ctrl_q[fsap_pkg::CTRL_TXE_REQ] && (|tx_empty))
         || (ctrl_q[fsap_pkg::CTRL_TXW_REQ] && (|tx_wml)));
    assign rx_req_d = rx_on
        && ((ctrl_q[fsap_pkg::CTRL_RXF_REQ] && (|rx_full))
         || (ctrl_q[fsap_pkg::CTRL_RXW_REQ] && (|rx_wml)));

    always_comb begin
        rd_d = 32'h0;
        unique case (wb_adr_in)
            fsap_pkg::OFS_CTRL:  rd_d = ctrl_q;
            fsap_pkg::OFS_FRAME: rd_d = frame_q;
            fsap_pkg::OFS_CLOCK: rd_d = clock_q;
            fsap_pkg::OFS_STATUS: begin
                rd_d[fsap_pkg::ST_FS_ERR]   = fs_err_q;
                rd_d[fsap_pkg::ST_WSTART]   = wstart_q;
                rd_d[fsap_pkg::ST_TX_EMPTY] = |tx_empty;
                rd_d[fsap_pkg::ST_RX_FULL]  = |rx_full;
                rd_d[fsap_pkg::ST_TX_REQ]   = tx_req_d;
                rd_d[fsap_pkg::ST_RX_REQ]   = rx_req_d;
            end
            fsap_pkg::OFS_RXDATA0: rd_d = rx_pd[0];
            fsap_pkg::OFS_RXDATA0 + fsap_pkg::OFS_STRIDE: rd_d = rx_pd[1];
            fsap_pkg::OFS_FPTR0: begin
                rd_d[AW:0] = tx_wp[0];
                rd_d[fsap_pkg::PTR_RD_LSB +: AW+1] = tx_rp[0];
            end
            fsap_pkg::OFS_FPTR0 + 8'h04: begin
                rd_d[AW:0] = tx_wp[1];
                rd_d[fsap_pkg::PTR_RD_LSB +: AW+1] = tx_rp[1];
            end
            fsap_pkg::OFS_FPTR0 + 8'h08: begin
                rd_d[AW:0] = rx_wp[0];
                rd_d[fsap_pkg::PTR_RD_LSB +: AW+1] = rx_rp[0];
            end
            fsap_pkg::OFS_FPTR0 + 8'h0C: begin
                rd_d[AW:0] = rx_wp[1];
                rd_d[fsap_pkg::PTR_RD_LSB +: AW+1] = rx_rp[1];
            end
            default: rd_d = 32'h0;
        endcase
    end

    assign wb_ack_out = ack_q;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ack_q      <= 1'b0;
            wb_dat_out <= 32'h0;
            tx_req_out <= 1'b0;
            rx_req_out <= 1'b0;
        end else begin
            ack_q      <= req;
            tx_req_out <= tx_req_d;
            rx_req_out <= rx_req_d;
            if (req) begin
                wb_dat_out <= rd_d;
            end
        end
    end

endmodule : fsap_top

// >>> verif/fsap_codec_model.sv
// Codec model: echoes each transmit pin onto its receive pin.
// Assumes bclk_in is the level of the bit clock wire.
`timescale 1ns/1ps
module fsap_codec_model (
    input  wire logic       bclk_in,
    input  wire logic [1:0] tx_in,
    output logic      [1:0] rx_out
);
    logic [1:0] bit_q = 2'h0;
    initial rx_out = 2'h0;
    always @(posedge bclk_in) bit_q <= tx_in;
    // Drive on the fall so the level is steady at the sampling rise
    always @(negedge bclk_in) rx_out <= bit_q;
endmodule : fsap_codec_model

// >>> verif/fsap_props.sv
// Checker of the audio port's bus answers and link output timing.
// Bound to fsap_top; sees only its ports.
`timescale 1ns/1ps
module fsap_props #(
    parameter int NCH = 2
) (
    input wire logic           clk_in,
    input wire logic           rst_n_in,
    input wire logic           wb_cyc_in,
    input wire logic           wb_stb_in,
    input wire logic           wb_we_in,
    input wire logic [7:0]     wb_adr_in,
    input wire logic [31:0]    wb_dat_out,
    input wire logic           wb_ack_out,
    input wire logic           bclk_out,
    input wire logic           bclk_oe_out,
    input wire logic           fs_out,
    input wire logic [NCH-1:0] tx_data_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    wire logic rq = wb_cyc_in && wb_stb_in;
    property p_ack_resp; rq && !wb_ack_out |=> wb_ack_out; endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("ack late");
    property p_ack_pulse; wb_ack_out |=> !wb_ack_out; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack long");
    property p_ack_idle; !rq |=> !wb_ack_out; endproperty
    a_ack_idle: assert property (p_ack_idle) else $error("stray ack");
    property p_dat_hold; wb_ack_out |=> $stable(wb_dat_out); endproperty
    a_dat_hold: assert property (p_dat_hold) else $error("data moved");
    property p_unmapped;
        wb_ack_out && !wb_we_in && wb_adr_in == 8'hF0 |-> wb_dat_out == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("hole read");
    property p_tx_fall; bclk_oe_out && $changed(tx_data_out) |-> !bclk_out;
    endproperty
    a_tx_fall: assert property (p_tx_fall) else $error("tx edge");
    property p_fs_fall; bclk_oe_out && $changed(fs_out) |-> !bclk_out;
    endproperty
    a_fs_fall: assert property (p_fs_fall) else $error("fs edge");
    property p_bclk_min;
        bclk_oe_out && $changed(bclk_out) |=> $stable(bclk_out) || !bclk_oe_out;
    endproperty
    a_bclk_min: assert property (p_bclk_min) else $error("bclk");
    c_write: cover property (wb_ack_out && wb_we_in);
    c_frame: cover property ($rose(fs_out));
    c_bclk: cover property ($rose(bclk_oe_out));
endmodule : fsap_props

bind fsap_top fsap_props #(.NCH(NCH)) u_props (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .bclk_out(bclk_out),
    .bclk_oe_out(bclk_oe_out), .fs_out(fs_out), .tx_data_out(tx_data_out));

// >>> verif/testbench.sv
// Self-checking bench of the audio port in bit clock master mode.
// Assumes the codec model echoes data, bclk half period of 4 clocks.
`timescale 1ns/1ps
module testbench;
    logic        clk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic        stop = 1'b0;
    logic        dbg = 1'b0;
    logic        ack, mclk, bclk, bclk_oe, fs, fs_oe, txr, rxr;
    logic [1:0]  txd, rxd;
    int          bad_count = 0;
    int          n_checks = 0;
    wire logic   bclk_w = bclk_oe & bclk;
    fsap_top dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(cyc),
        .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF),
        .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
        .stop_mode_in(stop), .debug_mode_in(dbg), .mclk_ext_in(1'b0),
        .mclk_out(mclk), .bclk_in(bclk_w), .bclk_out(bclk),
        .bclk_oe_out(bclk_oe), .fs_in(1'b0), .fs_out(fs), .fs_oe_out(fs_oe),
        .tx_data_out(txd), .rx_data_in(rxd), .tx_req_out(txr),
        .rx_req_out(rxr));
    fsap_codec_model codec (.bclk_in(bclk_w), .tx_in(txd), .rx_out(rxd));
    initial forever #25 clk_in = ~clk_in;
    task automatic chk(input logic [31:0] got, exp, input string m);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t %s", $time, m);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_in);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        do @(posedge clk_in); while (ack !== 1'b1);
        q = rdat;
        {cyc, stb} <= 2'b00;
    endtask : wb
    task automatic watch(output int tg, output logic fsh);
        logic p = bclk;
        tg = 0;
        fsh = 1'b0;
        repeat (40) begin
            @(posedge clk_in);
            tg += int'(bclk !== p);
            p = bclk;
            fsh = fsh | (fs !== 1'b0);
        end
    endtask : watch
    task automatic t_setup;
        logic [31:0] q;
        int tg;
        logic fsh;
        wb(1'b1, fsap_pkg::OFS_CLOCK, 32'h0001_0203, q);
        wb(1'b0, fsap_pkg::OFS_CLOCK, 32'h0, q);
        chk(q, 32'h0001_0203, "clock setup");
        wb(1'b1, fsap_pkg::OFS_CLOCK, 32'h0000_0001, q);
        wb(1'b1, fsap_pkg::OFS_FRAME, 32'h0200_0C07, q);
        wb(1'b0, fsap_pkg::OFS_FRAME, 32'h0, q);
        chk(q, 32'h0200_0C07, "13-word frame");
        wb(1'b1, fsap_pkg::OFS_FRAME, 32'h0200_0007, q);
        wb(1'b1, fsap_pkg::OFS_CTRL, 32'h0000_000C, q);
        watch(tg, fsh);
        chk(32'(tg inside {9, 10}), 32'h1, "bclk toggles");
        chk({30'h0, fsh, fs_oe}, 32'h0, "fs without path");
        for (int i = 0; i < 9; i++) begin
            wb(1'b1, fsap_pkg::OFS_TXDATA0, 32'hA5, q);
            wb(1'b1, fsap_pkg::OFS_TXDATA0 + fsap_pkg::OFS_STRIDE, 32'h3C, q);
        end
        wb(1'b0, fsap_pkg::OFS_FPTR0, 32'h0, q);
        chk(q, 32'h0000_0008, "tx0 pointers");
        wb(1'b0, 8'hF0, 32'h0, q);
        chk(q, 32'h0, "unmapped read");
        $display("test setup done");
    endtask : t_setup
    task automatic t_run;
        logic [31:0] q;
        int tg;
        logic fsh;
        int n = 0;
        stop <= 1'b1;
        dbg <= 1'b1;
        wb(1'b1, fsap_pkg::OFS_CTRL, 32'h0000_00FF, q);
        do begin
            wb(1'b0, fsap_pkg::OFS_STATUS, 32'h0, q);
            n++;
        end while (q[3:2] !== 2'b11 && n < 400);
        chk({28'h0, q[3:0]}, 32'hE, "status flags");
        chk({30'h0, fs_oe, bclk_oe}, 32'h3, "drive enables");
        chk({30'h0, txr, rxr}, 32'h3, "requests");
        wb(1'b1, fsap_pkg::OFS_CTRL, 32'h0, q);
        stop <= 1'b0;
        dbg <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            wb(1'b0, fsap_pkg::OFS_RXDATA0, 32'h0, q);
            if (i > 0) chk(q, 32'hD2, "rx0 word");
            wb(1'b0, fsap_pkg::OFS_RXDATA0 + fsap_pkg::OFS_STRIDE, 32'h0, q);
            if (i > 0) chk(q, 32'h1E, "rx1 word");
        end
        wb(1'b0, fsap_pkg::OFS_FPTR0 + 8'h08, 32'h0, q);
        chk(q, 32'h0008_0008, "rx0 pointers");
        watch(tg, fsh);
        chk(32'(fsh), 32'h0, "fs after disable");
        $display("test run done");
    endtask : t_run
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude
    initial begin
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        t_setup();
        t_run();
        conclude();
    end
    initial begin
        #1000000;
        bad_count++;
        conclude();
    end
endmodule : testbench
